// ---- design/decode_pkg.sv ----
// Purpose: Shared constants and types for the instruction format decoder
// Assumes: 16-bit words, bit 0 of the documented numbering is the word MSB
// Notes:   Register offsets are byte addresses on the plain register port
package decode_pkg;

  // Word and field widths
  localparam int WORD_W = 16;
  localparam int REG_W  = 3;
  localparam int MAX_WORDS = 4;

  // Base word layout, LSB numbering (documented bit n is [15-n])
  localparam int OPC_LSB   = 8;
  localparam int MODE1_POS = 7;
  localparam int SEL1_LSB  = 4;
  localparam int MODE2_POS = 3;
  localparam int SEL2_LSB  = 0;
  localparam int IMM4_LSB  = 4;
  localparam int LEN1_LSB  = 8;
  localparam int LEN2_LSB  = 0;

  // Register map, byte offsets
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] COUNT_OFS  = 5'h08;
  localparam logic [4:0] OP1_OFS    = 5'h0C;
  localparam logic [4:0] OP2_OFS    = 5'h10;

  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;

  // Address step between consecutive storage words
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // Six generalized formats
  typedef enum logic [2:0] {
    FMT_REG_REG,
    FMT_IMM_REG,
    FMT_MEM_REG,
    FMT_DIR_REG,
    FMT_MEM_MEM,
    FMT_MEM_MEM_EXT
  } fmt_t;

  // What an operand result designates
  typedef enum logic [1:0] {
    KIND_REG,
    KIND_IMM,
    KIND_MEM
  } kind_t;

  // Formed operand: register number, value, or storage address
  typedef struct packed {
    kind_t             kind;
    logic [WORD_W-1:0] value;
    logic              byte_lo;
  } operand_t;

  // Per-opcode attributes supplied with a start request
  typedef struct packed {
    fmt_t       fmt;
    logic       preidx;
    logic [1:0] mode_fixed;
    logic [1:0] mode_value;
  } instr_attr_t;

endpackage

// ---- design/instr_format_decode.sv ----
// Purpose: Fetch an instruction and form both operand locations
// Assumes: Storage answers reads later with mem_valid; register file read is
//          asynchronous on reg_sel
// Notes:   Register port: one-cycle strobes, read data the cycle after
// What this block does
// [RULE_01] Base word: 8-bit opcode, two operand fields
// [RULE_02] Fetch one to four words per instruction
// [RULE_03] Register format: two 4-bit register fields
// [RULE_04] Immediate format: 4-bit field is operand one
// [RULE_05] Memory/register: word two addresses operand one
// [RULE_06] Direct format: word two is immediate operand
// [RULE_07] Memory/memory: words two, three give addresses
// [RULE_08] Extended: word four gives both byte lengths
// [RULE_09] Bit 8, bit 12 select operand modes
// [RULE_10] Clear mode direct; set mode location holds address
// [RULE_11] Pointer fetch addresses are always even
// [RULE_12] Nonzero register field enables indexing
// [RULE_13] One-word instructions never index
// [RULE_14] Pre-indexing adds before the pointer fetch
// [RULE_15] Others post-index after the pointer fetch
// [RULE_16] Direct type indexes the immediate value
// [RULE_17] Index sums wrap to 16 bits
// [RULE_18] Wraparound raises no flag
// [RULE_19] Wrong fixed mode bit gives no-operation
// [RULE_20] Low address bit selects byte
// [RULE_21] Indirection is single level
`timescale 1ns/1ps
module instr_format_decode
  import decode_pkg::*;
(
  input  wire logic                  ref_clk,      // 40 MHz clock
  input  wire logic                  reset_n,      // Synchronous reset
  input  wire logic                  start,        // Decode request pulse
  input  wire logic [15:0]           instr_addr,   // Instruction word address
  input  wire decode_pkg::instr_attr_t attr,       // Opcode attributes
  output logic                       done_q,       // Operands ready pulse
  output logic                       nop_q,        // Decoded as no-operation
  output logic [7:0]                 opcode_q,     // Operation code
  output logic [2:0]                 words_q,      // Instruction length, words
  output decode_pkg::operand_t       op1_q,        // First operand
  output decode_pkg::operand_t       op2_q,        // Second operand
  output logic [7:0]                 first_field_length_q,  // Field length one
  output logic [7:0]                 second_field_length_q, // Field length two
  output logic                       mem_rd_q,     // Storage read pulse
  output logic [15:0]                mem_addr_q,   // Storage word address
  input  wire logic                  mem_valid,    // Storage read answer
  input  wire logic [15:0]           mem_rdata,    // Storage read data
  output logic [2:0]                 reg_sel_q,    // Register file select
  input  wire logic [15:0]           reg_rdata,    // Selected register contents
  input  wire logic [4:0]            bus_addr,     // Register byte address
  input  wire logic [31:0]           bus_wdata,    // Register write data
  input  wire logic                  bus_wr,       // Register write strobe
  input  wire logic                  bus_rd,       // Register read strobe
  output logic [31:0]                bus_rdata_q   // Register read data
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_FETCH,
    S_OPER,
    S_REG,
    S_ADDR,
    S_PTR,
    S_DONE
  } state_t;

  state_t            state_q;
  logic [15:0]       word_q [MAX_WORDS];
  logic [1:0]        widx_q;
  logic              opk_q;
  logic              reg_op_q;
  logic              need_x_q;
  logic [15:0]       base_val_q;
  logic [15:0]       x_q;
  logic              en_q;
  logic [15:0]       count_q;
  instr_attr_t       attr_q;
  logic [2:0]        nwords;
  logic              mode_k;
  logic [2:0]        sel_k;
  logic              is_mem_k;
  logic              is_reg_k;
  logic [15:0]       addr_word_k;
  logic [15:0]       sum_pre;
  logic              bad_mode;
  operand_t          result;

  // Length in words per format
  always_comb
  begin
    case (attr_q.fmt)
      FMT_REG_REG, FMT_IMM_REG: nwords = 3'd1;       // RULE_02
      FMT_MEM_REG, FMT_DIR_REG: nwords = 3'd2;       // RULE_02
      FMT_MEM_MEM:              nwords = 3'd3;       // RULE_02
      default:                  nwords = 3'd4;       // RULE_02
    endcase
  end

  // Fields of the operand being formed
  always_comb
  begin
    mode_k      = opk_q ? word_q[0][MODE2_POS] : word_q[0][MODE1_POS];         // RULE_09
    sel_k       = opk_q ? word_q[0][SEL2_LSB +: REG_W] : word_q[0][SEL1_LSB +: REG_W]; // RULE_10
    addr_word_k = opk_q ? word_q[2] : word_q[1];
    is_mem_k    = opk_q ? (attr_q.fmt inside {FMT_MEM_MEM, FMT_MEM_MEM_EXT})
                        : (attr_q.fmt inside {FMT_MEM_REG, FMT_MEM_MEM, FMT_MEM_MEM_EXT});
    is_reg_k    = opk_q ? (attr_q.fmt inside {FMT_REG_REG, FMT_IMM_REG, FMT_MEM_REG, FMT_DIR_REG})
                        : (attr_q.fmt == FMT_REG_REG);
  end

  // Index sum, carry beyond 16 bits dropped without any flag
  assign sum_pre = base_val_q + x_q;                                 // RULE_17 RULE_18

  // Fixed mode bits checked against the base word
  assign bad_mode = (attr_q.mode_fixed[0] && (word_q[0][MODE1_POS] != attr_q.mode_value[0]))
                 || (attr_q.mode_fixed[1] && (word_q[0][MODE2_POS] != attr_q.mode_value[1])); // RULE_19

  // Result for direct address and immediate cases
  always_comb
  begin
    result.kind    = is_mem_k ? KIND_MEM : KIND_IMM;
    result.value   = sum_pre;                                        // RULE_14 RULE_15 RULE_16
    result.byte_lo = sum_pre[0];                                     // RULE_20
  end

  // Control register write
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      en_q <= CTRL_EN_RST;
    else if (bus_wr && bus_addr == CTRL_OFS)
      en_q <= bus_wdata[0];
  end

  // Register read port, answer one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      bus_rdata_q <= 32'h0000_0000;
    else if (bus_rd)
    begin
      case (bus_addr)
        CTRL_OFS:   bus_rdata_q <= {31'h0000_0000, en_q};
        STATUS_OFS: bus_rdata_q <= {30'h0000_0000, nop_q, state_q != S_IDLE};
        COUNT_OFS:  bus_rdata_q <= {16'h0000, count_q};
        OP1_OFS:    bus_rdata_q <= {15'h0000, op1_q.value, op1_q.byte_lo};
        OP2_OFS:    bus_rdata_q <= {15'h0000, op2_q.value, op2_q.byte_lo};
        default:    bus_rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      bus_rdata_q <= 32'h0000_0000;
  end

  // Decoded instruction counter
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      count_q <= 16'h0000;
    else if (done_q)
      count_q <= count_q + 16'h0001;
  end

  // Instruction word storage, indexed by word number
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < MAX_WORDS; i++)
        word_q[i] <= 16'h0000;
    end
    else if (state_q == S_FETCH && mem_valid)
      word_q[widx_q] <= mem_rdata;                                   // RULE_01 RULE_02
  end

  // Main sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_q    <= S_IDLE;
      attr_q     <= '0;
      widx_q     <= 2'd0;
      opk_q      <= 1'b0;
      reg_op_q   <= 1'b0;
      need_x_q   <= 1'b0;
      base_val_q <= 16'h0000;
      x_q        <= 16'h0000;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= 16'h0000;
      reg_sel_q  <= 3'd0;
      done_q     <= 1'b0;
      nop_q      <= 1'b0;
      opcode_q   <= 8'h00;
      words_q    <= 3'd0;
      op1_q      <= '0;
      op2_q      <= '0;
      first_field_length_q  <= 8'h00;
      second_field_length_q <= 8'h00;
    end
    else
    begin
      mem_rd_q <= 1'b0;
      done_q   <= 1'b0;
      case (state_q)
        // Wait for a request and fetch the base word
        S_IDLE:
        begin
          if (start && en_q)
          begin
            attr_q     <= attr;
            widx_q     <= 2'd0;
            mem_rd_q   <= 1'b1;
            mem_addr_q <= {instr_addr[15:1], 1'b0};
            state_q    <= S_FETCH;
          end
        end
        // Collect base and extension words
        S_FETCH:
        begin
          if (mem_valid)
          begin
            if ({1'b0, widx_q} + 3'd1 < nwords)                      // RULE_02
            begin
              widx_q     <= widx_q + 2'd1;
              mem_rd_q   <= 1'b1;
              mem_addr_q <= mem_addr_q + WORD_STEP;
            end
            else
            begin
              opk_q   <= 1'b0;
              words_q <= nwords;
              state_q <= S_OPER;
            end
          end
        end
        // Start forming one operand
        S_OPER:
        begin
          opcode_q <= word_q[0][OPC_LSB +: 8];                       // RULE_01
          x_q      <= 16'h0000;
          reg_op_q <= is_reg_k;
          if (bad_mode)
          begin
            nop_q   <= 1'b1;                                         // RULE_19
            state_q <= S_DONE;
          end
          else if (is_reg_k)
          begin
            // Register operand: number when direct, contents when indirect
            if (mode_k)
            begin
              reg_sel_q <= sel_k;                                    // RULE_10
              state_q   <= S_REG;
            end
            else
            begin
              if (opk_q)
                op2_q <= '{KIND_REG, {12'h000, 1'b0, sel_k}, 1'b0};  // RULE_03
              else
                op1_q <= '{KIND_REG, {12'h000, 1'b0, sel_k}, 1'b0};  // RULE_03
              opk_q   <= 1'b1;
              state_q <= opk_q ? S_DONE : S_OPER;
            end
          end
          else if (!opk_q && attr_q.fmt == FMT_IMM_REG)
          begin
            // Four-bit immediate, never indexed
            op1_q   <= '{KIND_IMM, {12'h000, word_q[0][IMM4_LSB +: 4]}, 1'b0}; // RULE_04 RULE_13
            opk_q   <= 1'b1;
            state_q <= S_OPER;
          end
          else
          begin
            // Address word or 16-bit immediate, indexed on nonzero field
            base_val_q <= addr_word_k;                               // RULE_05 RULE_06 RULE_07
            need_x_q   <= (sel_k != 3'd0);                           // RULE_12
            reg_sel_q  <= sel_k;
            state_q    <= (sel_k != 3'd0) ? S_REG : S_ADDR;          // RULE_12
          end
        end
        // Take register contents as index or as pointer
        S_REG:
        begin
          if (reg_op_q)
          begin
            if (opk_q)
              op2_q <= '{KIND_MEM, reg_rdata, reg_rdata[0]};         // RULE_10 RULE_20
            else
              op1_q <= '{KIND_MEM, reg_rdata, reg_rdata[0]};         // RULE_10 RULE_20
            opk_q   <= 1'b1;
            state_q <= opk_q ? S_DONE : S_OPER;
          end
          else
          begin
            x_q     <= reg_rdata;
            state_q <= S_ADDR;
          end
        end
        // Apply direct result or launch the pointer fetch
        S_ADDR:
        begin
          if (is_mem_k && mode_k)
          begin
            mem_rd_q <= 1'b1;
            if (attr_q.preidx)
            begin
              mem_addr_q <= {sum_pre[15:1], 1'b0};                   // RULE_11 RULE_14
              x_q        <= 16'h0000;
            end
            else
              mem_addr_q <= {base_val_q[15:1], 1'b0};                // RULE_11 RULE_15
            state_q <= S_PTR;
          end
          else
          begin
            if (opk_q)
              op2_q <= result;                                       // RULE_15 RULE_17
            else
              op1_q <= result;                                       // RULE_16 RULE_17
            opk_q   <= 1'b1;
            state_q <= opk_q ? S_DONE : S_OPER;
          end
        end
        // Fetched pointer is final, post-index added if any
        S_PTR:
        begin
          if (mem_valid)
          begin
            if (opk_q)
              op2_q <= '{KIND_MEM, mem_rdata + x_q, mem_rdata[0] ^ x_q[0]}; // RULE_15 RULE_21
            else
              op1_q <= '{KIND_MEM, mem_rdata + x_q, mem_rdata[0] ^ x_q[0]}; // RULE_15 RULE_21
            opk_q   <= 1'b1;
            state_q <= opk_q ? S_DONE : S_OPER;
          end
        end
        // Report lengths and completion
        S_DONE:
        begin
          if (attr_q.fmt == FMT_MEM_MEM_EXT)
          begin
            first_field_length_q  <= word_q[3][LEN1_LSB +: 8];       // RULE_08
            second_field_length_q <= word_q[3][LEN2_LSB +: 8];       // RULE_08
          end
          else
          begin
            first_field_length_q  <= 8'h00;
            second_field_length_q <= 8'h00;
          end
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
      if (state_q == S_IDLE && start && en_q)
        nop_q <= 1'b0;
    end
  end

endmodule

// ---- tb/instr_decode_asserts.sv ----
// Purpose: Port checks for the instruction format decoder
// Assumes: One clock, synchronous active-low reset
// Notes:   Read counter spans one decode and clears at each result
`timescale 1ns/1ps
module instr_decode_asserts
  import decode_pkg::*;
(
  input wire logic                 ref_clk,               // Clock
  input wire logic                 reset_n,               // Reset, active low
  input wire logic                 done_q,                // Result pulse
  input wire logic                 nop_q,                 // No-operation
  input wire logic [2:0]           words_q,               // Length in words
  input wire decode_pkg::operand_t op1_q,                 // First operand
  input wire decode_pkg::operand_t op2_q,                 // Second operand
  input wire logic [7:0]           first_field_length_q,  // Length one
  input wire logic [7:0]           second_field_length_q, // Length two
  input wire logic                 mem_rd_q,              // Storage read
  input wire logic [15:0]          mem_addr_q             // Storage address
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] rd_cnt_q;
  // Storage reads since the last result
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || done_q)
      rd_cnt_q <= 3'h0;
    else if (mem_rd_q)
      rd_cnt_q <= rd_cnt_q + 3'h1;
  end
  property p_even; mem_rd_q |-> !mem_addr_q[0]; endproperty
  a_even: assert property (p_even) else $error("odd storage read address");
  property p_rd_pulse; mem_rd_q |=> !mem_rd_q; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");
  property p_words; done_q |-> words_q inside {[1:4]}; endproperty
  a_words: assert property (p_words) else $error("bad length");
  property p_fetched; done_q |-> rd_cnt_q >= words_q; endproperty
  a_fetched: assert property (p_fetched) else $error("words not all fetched");
  property p_one_word; done_q && words_q == 3'h1 |-> rd_cnt_q == 3'h1; endproperty
  a_one_word: assert property (p_one_word) else $error("extra read in one-word decode");
  property p_byte; done_q && op1_q.kind == KIND_MEM |-> op1_q.byte_lo == op1_q.value[0]; endproperty
  a_byte: assert property (p_byte) else $error("byte select wrong");
  property p_len; done_q && words_q != 3'h4 |-> {first_field_length_q, second_field_length_q} == 16'h0; endproperty
  a_len: assert property (p_len) else $error("length without fourth word");
  property p_regnum; done_q && op2_q.kind == KIND_REG |-> op2_q.value < 16'h8; endproperty
  a_regnum: assert property (p_regnum) else $error("register number too wide");
  property p_imm4; done_q && !nop_q && words_q == 3'h1 && op1_q.kind == KIND_IMM |-> op1_q.value < 16'h10; endproperty
  a_imm4: assert property (p_imm4) else $error("short immediate too wide");
  c_one: cover property (done_q && words_q == 3'h1);
  c_ext: cover property (done_q && words_q == 3'h4);
  c_nop: cover property (done_q && nop_q);
endmodule

bind instr_format_decode instr_decode_asserts u_chk (.ref_clk, .reset_n, .done_q, .nop_q, .words_q, .op1_q,
  .op2_q, .first_field_length_q, .second_field_length_q, .mem_rd_q, .mem_addr_q);

// ---- tb/store_regfile_model.sv ----
// Purpose: Main storage and general register file beside the decoder
// Assumes: 256 storage words mirrored over the address space
// Notes:   slow stretches answers; data toggles outside an answer
`timescale 1ns/1ps
module store_regfile_model
(
  input wire logic        ref_clk,    // Clock
  input wire logic        reset_n,    // Reset, active low
  input wire logic        slow,       // Stretch answers
  input wire logic        mem_rd_q,   // Read request
  input wire logic [15:0] mem_addr_q, // Read address
  input wire logic [2:0]  reg_sel_q,  // Register select
  output logic            mem_valid,  // Answer pulse
  output logic [15:0]     mem_rdata,  // Answer data
  output logic [15:0]     reg_rdata   // Selected register
);
  logic [15:0] mem [0:255];
  logic [15:0] regs [0:7];
  logic [15:0] addr_q;
  logic [2:0]  wait_q;
  // Register file read is combinational
  assign reg_rdata = regs[reg_sel_q];
  // One answer per request, data not held afterwards
  always_ff @(posedge ref_clk)
  begin
    mem_valid <= 1'b0;
    if (!reset_n)
    begin
      wait_q <= 3'h0;
      mem_rdata <= 16'h0000;
    end
    else if (mem_rd_q)
    begin
      addr_q <= mem_addr_q;
      wait_q <= slow ? 3'h4 : 3'h1;
      mem_rdata <= ~mem_rdata;
    end
    else
    begin
      wait_q <= (wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0;
      mem_valid <= (wait_q == 3'h1);
      mem_rdata <= (wait_q == 3'h1) ? mem[addr_q[8:1]] : ~mem_rdata;
    end
  end
endmodule

// ---- tb/tb_instr_format_decode.sv ----
// Purpose: Self-checking bench for the instruction format decoder
// Assumes: Storage and register model answer behind the decoder
// Notes:   Expected results queued by the driver, checked at done
`timescale 1ns/1ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, x); end end
module tb_instr_format_decode;
  import decode_pkg::*;
  typedef struct packed {logic nop; logic [7:0] opc; logic [2:0] words; operand_t o1; operand_t o2;
    logic [15:0] lens;} expect_t;
  logic        ref_clk, reset_n, start, done_q, nop_q, mem_rd_q, mem_valid, bus_wr, bus_rd, slow, rd_d, last_nop;
  logic [15:0] instr_addr, mem_addr_q, mem_rdata, reg_rdata;
  logic [7:0]  opcode_q, len1, len2;
  logic [2:0]  words_q, reg_sel_q;
  logic [4:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata_q, b_exp;
  instr_attr_t attr;
  operand_t    op1_q, op2_q;
  expect_t     e;
  expect_t     q[$];
  logic [31:0] bq[$];
  int          n_mismatch, checks_done, n_done, seed;
  instr_format_decode u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .start(start), .instr_addr(instr_addr),
    .attr(attr), .done_q(done_q), .nop_q(nop_q), .opcode_q(opcode_q), .words_q(words_q), .op1_q(op1_q),
    .op2_q(op2_q), .first_field_length_q(len1), .second_field_length_q(len2), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_valid(mem_valid), .mem_rdata(mem_rdata), .reg_sel_q(reg_sel_q),
    .reg_rdata(reg_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q));
  store_regfile_model u_mem (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .reg_sel_q(reg_sel_q), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
    .reg_rdata(reg_rdata));
  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One register port cycle; reads queue their expectation
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr <= wr;
    bus_rd <= !wr;
    bus_addr <= a;
    bus_wdata <= d;
    if (!wr)
      bq.push_back(d);
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
  endtask
  function automatic logic [15:0] rdw(input logic [15:0] a);
    return u_mem.mem[a[8:1]];
  endfunction
  // Operand location from mode, select field and address word
  function automatic operand_t opnd(input logic isreg, m, pre, input logic [2:0] s, input logic [15:0] w);
    logic [15:0] x;
    logic [15:0] v;
    kind_t       k;
    x = (s != 3'h0) ? u_mem.regs[s] : 16'h0000;
    k = (isreg && !m) ? KIND_REG : KIND_MEM;
    if (isreg)
      v = m ? u_mem.regs[s] : {13'h0, s};
    else if (!m)
      v = w + x;
    else if (pre)
      v = rdw(w + x);
    else
      v = rdw(w) + x;
    // Byte select only for located operands; register numbers carry none
    return '{k, v, (k == KIND_REG) ? 1'b0 : v[0]};
  endfunction
  task automatic decode_one(input fmt_t f);
    logic [15:0] w[4];
    logic [31:0] r;
    expect_t     x;
    int          n;
    instr_attr_t a;
    r = $random(seed);
    for (n = 0; n < 8; n++)
      u_mem.regs[n] = 16'($random(seed));
    for (n = 0; n < 4; n++)
      w[n] = 16'($random(seed));
    if (f == FMT_DIR_REG)
      w[0][7] = 1'b0;
    for (n = 0; n < 4; n++)
      u_mem.mem[8'(r[15:9] * 2 + n)] = w[n];
    x.opc = w[0][15:8];
    x.words = (f < FMT_MEM_REG) ? 3'h1 : (f < FMT_MEM_MEM) ? 3'h2 : (f == FMT_MEM_MEM) ? 3'h3 : 3'h4;
    x.lens = (f == FMT_MEM_MEM_EXT) ? w[3] : 16'h0;
    a = '{f, f == FMT_MEM_REG && r[0], r[2:1] & r[4:3], r[6:5]};
    if (f == FMT_IMM_REG || f == FMT_DIR_REG)
      a.mode_fixed[0] = 1'b0;
    x.nop = |(a.mode_fixed & (a.mode_value ^ {w[0][3], w[0][7]}));
    x.o1 = opnd(f == FMT_REG_REG, w[0][7], a.preidx, w[0][6:4], w[1]);
    if (f == FMT_DIR_REG)
      x.o1.kind = KIND_IMM;
    if (f == FMT_IMM_REG)
      x.o1 = '{KIND_IMM, {12'h0, w[0][7:4]}, 1'b0};
    x.o2 = opnd(f < FMT_MEM_MEM, w[0][3], 1'b0, w[0][2:0], w[2]);
    q.push_back(x);
    n = n_done;
    slow <= r[7];
    @(posedge ref_clk);
    start <= 1'b1;
    attr <= a;
    instr_addr <= {7'h0, r[15:9], 2'h0};
    @(posedge ref_clk);
    start <= 1'b0;
    for (int k = 0; k < 300 && n_done == n; k++)
      @(posedge ref_clk);
    if (n_done == n)
    begin
      n_mismatch++;
      results();
    end
  endtask
  // Compare results and read data as they appear
  always @(posedge ref_clk) rd_d <= bus_rd;
  always @(negedge ref_clk)
  begin
    if (rd_d === 1'b1)
    begin
      b_exp = (bq.size() != 0) ? bq.pop_front() : 32'hFFFFFFFF;
      `CHK(bus_rdata_q, b_exp)
    end
    if (done_q === 1'b1)
    begin
      e = (q.size() != 0) ? q.pop_front() : '1;
      last_nop = e.nop;
      `CHK(nop_q, e.nop)
      `CHK(opcode_q, e.opc)
      `CHK(words_q, e.words)
      `CHK({len1, len2}, e.lens)
      if (!e.nop)
      begin
        `CHK(op1_q, e.o1)
        `CHK(op2_q, e.o2)
      end
      n_done++;
    end
  end
  // Reset, random decodes, refused start, register checks
  initial
  begin
    {reset_n, start, instr_addr, bus_wr, bus_rd, bus_addr, bus_wdata, slow} = '0;
    attr = '0;
    {n_mismatch, checks_done, n_done} = '0;
    seed = 32'h292E614F;
    // Defined storage behind every pointer the decodes may follow
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = 16'($random(seed));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h1);
    for (int i = 0; i < 90; i++)
      decode_one(fmt_t'(i % 6));
    bus(1'b1, CTRL_OFS, 32'h0);
    bus(1'b0, CTRL_OFS, 32'h0);
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (12) @(posedge ref_clk);
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    bus(1'b0, 5'h14, 32'h0);
    bus(1'b0, STATUS_OFS, {30'h0, last_nop, 1'b0});
    bus(1'b0, COUNT_OFS, 32'(n_done));
    decode_one(FMT_MEM_MEM_EXT);
    results();
  end
endmodule
